// >>> stc_pkg.sv
// Purpose: constants and carrier types of the tick timer
// Assumes: 32-bit word register port, byte addresses
// Notes: calibration word is fixed, no reference clock
package stc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 24;
   // register byte offsets
   localparam logic [7:0] OFS_CSR = 8'h10;
   localparam logic [7:0] OFS_RVR = 8'h14;
   localparam logic [7:0] OFS_CVR = 8'h18;
   localparam logic [7:0] OFS_CALIB = 8'h1c;
   localparam logic [7:0] OFS_IST = 8'h20;
   localparam logic [7:0] OFS_IMSK = 8'h24;
   // control/status fields
   localparam int CSR_EN_BIT = 0;
   localparam int CSR_TICKINT_BIT = 1;
   localparam int CSR_CLKSRC_BIT = 2;
   localparam int CSR_ZERO_BIT = 16;
   // calibration fields
   localparam int CAL_NO_REFERENCE_CLOCK_FLAG_BIT = 31;
   localparam int CAL_INEXACT_CALIBRATION_FLAG_BIT = 30;
   localparam logic [CNT_W-1:0] TEN_MS_COUNT = 24'h000000;
   localparam logic [DATA_W-1:0] CALIB_VAL = 32'hc0000000;
   // interrupt status fields
   localparam int IRQ_W = 1;
   localparam int IRQ_ZERO_BIT = 0;
   // reset values
   localparam logic [CNT_W-1:0] RVR_RST = 24'h000000;
   localparam logic [CNT_W-1:0] CVR_RST = 24'h000000;
   localparam logic [IRQ_W-1:0] IMSK_RST = 1'h0;
   localparam logic [IRQ_W-1:0] IST_RST = 1'h0;
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } stc_bus_req_t;
endpackage

// >>> stc_tick_timer.sv
// Purpose: 24-bit down-counting system tick timer with calibration word
// Assumes: word accesses only; one clock SYS_CLK, sync reset RST
// Notes: counter steps only while the controller clock runs
//
// Functional notes
// [RULE_01] calibration top flag always reads one
// [RULE_02] inexact_calibration_flag flag always reads one
// [RULE_03] ten ms count field reads zero
// [RULE_04] software derives calibration from clock frequency
// [RULE_05] counter steps only on controller clock
// [RULE_06] gated controller clock holds the counter
// [RULE_07] software uses full word accesses only
// [RULE_08] software: reload, clear current, then control
// [RULE_09] decrement to zero, reload, keep counting
// [RULE_10] current write clears value, flag, no exception
// [RULE_11] reached zero flag clears on control read
// [RULE_12] debugger halt stops the decrement
// [RULE_13] calibration writes ignored, reserved bits zero
module stc_tick_timer
   import stc_pkg::*;
(
   input wire logic SYS_CLK, // system clock
   input wire logic RST, // sync reset, active high
   input wire logic CE, // clock enable, freezes all state
   input wire stc_pkg::stc_bus_req_t BUS_REQ, // register request
   input wire logic IC_CLK_RUN, // controller clock running
   input wire logic DBG_HALT, // processor halted by debugger
   output logic [stc_pkg::DATA_W-1:0] RDATA, // read data, cycle after read
   output logic IRQ // level interrupt
);
   logic run_s1, run_s2;
   logic halt_s1, halt_s2;
   logic ctrl_en_reg;
   logic ctrl_tickint_reg;
   logic zero_flag_reg;
   logic [CNT_W-1:0] rvr_reg;
   logic [CNT_W-1:0] cvr_reg;
   logic [IRQ_W-1:0] ist_reg, ist_next;
   logic [IRQ_W-1:0] imsk_reg, imsk_next;
   logic [DATA_W-1:0] rdata_reg;
   logic irq_reg;
   logic [DATA_W-1:0] rd_mux;
   logic csr_wr, csr_rd, rvr_wr, cvr_wr, ist_wr, imsk_wr;
   logic cnt_step, hit_zero;

   assign csr_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_CSR);
   assign csr_rd = BUS_REQ.rd && (BUS_REQ.addr == OFS_CSR);
   assign rvr_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_RVR);
   assign cvr_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_CVR);
   assign ist_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_IST);
   assign imsk_wr = BUS_REQ.wr && (BUS_REQ.addr == OFS_IMSK);

   // pin synchronisers
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         run_s1 <= 1'b0;
         run_s2 <= 1'b0;
         halt_s1 <= 1'b0;
         halt_s2 <= 1'b0;
      end else if (CE) begin
         run_s1 <= IC_CLK_RUN;
         run_s2 <= run_s1;
         halt_s1 <= DBG_HALT;
         halt_s2 <= halt_s1;
      end
   end

   // counter advances only on a running, unhalted controller clock
   assign cnt_step = ctrl_en_reg && run_s2 && !halt_s2; // [RULE_05] [RULE_06] [RULE_12]
   // the zero event comes only from counting 1 to 0
   assign hit_zero = cnt_step && !cvr_wr && (cvr_reg == 24'h000001); // [RULE_09]

   // control register
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ctrl_en_reg <= 1'b0;
         ctrl_tickint_reg <= 1'b0;
      end else if (CE && csr_wr) begin
         ctrl_en_reg <= BUS_REQ.wdata[CSR_EN_BIT];
         ctrl_tickint_reg <= BUS_REQ.wdata[CSR_TICKINT_BIT];
      end
   end

   // reload register
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rvr_reg <= RVR_RST;
      end else if (CE && rvr_wr) begin
         rvr_reg <= BUS_REQ.wdata[CNT_W-1:0];
      end
   end

   // current value: write clears, zero reloads, otherwise decrement
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cvr_reg <= CVR_RST;
      end else if (CE) begin
         if (cvr_wr) begin
            cvr_reg <= '0; // [RULE_10]
         end else if (cnt_step) begin
            if (cvr_reg == '0) begin
               cvr_reg <= rvr_reg; // [RULE_09]
            end else begin
               cvr_reg <= cvr_reg - 24'h000001; // [RULE_09]
            end
         end
      end
   end

   // reached zero flag: set wins over read clear; a current write blocks the set and clears
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         zero_flag_reg <= 1'b0;
      end else if (CE) begin
         if (hit_zero) begin
            zero_flag_reg <= 1'b1;
         end else if (csr_rd || cvr_wr) begin
            zero_flag_reg <= 1'b0; // [RULE_10] [RULE_11]
         end
      end
   end

   // sticky tick exception status, write one to clear, set wins
   always_comb begin
      ist_next = ist_reg;
      if (ist_wr) begin
         ist_next = ist_next & ~BUS_REQ.wdata[IRQ_W-1:0];
      end
      if (hit_zero && ctrl_tickint_reg) begin
         ist_next[IRQ_ZERO_BIT] = 1'b1;
      end
   end

   always_comb begin
      imsk_next = imsk_reg;
      if (imsk_wr) begin
         imsk_next = BUS_REQ.wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ist_reg <= IST_RST;
         imsk_reg <= IMSK_RST;
         irq_reg <= 1'b0;
      end else if (CE) begin
         ist_reg <= ist_next;
         imsk_reg <= imsk_next;
         irq_reg <= |(ist_next & imsk_next);
      end
   end

   // read mux; calibration word is constant, writes to it fall through
   always_comb begin
      rd_mux = '0;
      unique case (BUS_REQ.addr)
         OFS_CSR: begin
            rd_mux[CSR_EN_BIT] = ctrl_en_reg;
            rd_mux[CSR_TICKINT_BIT] = ctrl_tickint_reg;
            rd_mux[CSR_CLKSRC_BIT] = 1'b1;
            rd_mux[CSR_ZERO_BIT] = zero_flag_reg;
         end
         OFS_RVR: rd_mux[CNT_W-1:0] = rvr_reg;
         OFS_CVR: rd_mux[CNT_W-1:0] = cvr_reg;
         OFS_CALIB: begin
            rd_mux = CALIB_VAL; // [RULE_01] [RULE_02] [RULE_13]
            rd_mux[CNT_W-1:0] = TEN_MS_COUNT; // [RULE_03]
         end
         OFS_IST: rd_mux[IRQ_W-1:0] = ist_reg;
         OFS_IMSK: rd_mux[IRQ_W-1:0] = imsk_reg;
         default: rd_mux = '0;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rdata_reg <= '0;
      end else if (CE) begin
         rdata_reg <= BUS_REQ.rd ? rd_mux : '0;
      end
   end

   assign RDATA = rdata_reg;
   assign IRQ = irq_reg;

   // checks
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   property p_calib_no_reference_clock_flag;
      CE && BUS_REQ.rd && (BUS_REQ.addr == OFS_CALIB) |=> RDATA[CAL_NO_REFERENCE_CLOCK_FLAG_BIT];
   endproperty
   a_calib_no_reference_clock_flag: assert property (p_calib_no_reference_clock_flag) // [RULE_01]
      else $error("no-reference flag read as zero");

   property p_calib_inexact_calibration_flag;
      CE && BUS_REQ.rd && (BUS_REQ.addr == OFS_CALIB) |=> RDATA[CAL_INEXACT_CALIBRATION_FLAG_BIT];
   endproperty
   a_calib_inexact_calibration_flag: assert property (p_calib_inexact_calibration_flag) // [RULE_02]
      else $error("inexact calibration flag read as zero");

   property p_calib_ten_ms_count;
      CE && BUS_REQ.rd && (BUS_REQ.addr == OFS_CALIB) |=> RDATA[CNT_W-1:0] == '0;
   endproperty
   a_calib_ten_ms_count: assert property (p_calib_ten_ms_count) // [RULE_03]
      else $error("ten ms count not zero");

   property p_calib_fixed;
      CE && BUS_REQ.wr && (BUS_REQ.addr == OFS_CALIB) ##2
      CE && BUS_REQ.rd && (BUS_REQ.addr == OFS_CALIB) |=> RDATA == CALIB_VAL;
   endproperty
   a_calib_fixed: assert property (p_calib_fixed) // [RULE_13]
      else $error("calibration word changed or reserved bits set");

   property p_no_step_hold;
      CE && !cnt_step && !cvr_wr |=> $stable(cvr_reg);
   endproperty
   a_no_step_hold: assert property (p_no_step_hold) // [RULE_05]
      else $error("counter moved without a controller clock step");

   property p_gated_hold;
      CE && !run_s2 && !cvr_wr ##1 CE && !run_s2 && !cvr_wr |=> cvr_reg == $past(cvr_reg, 2);
   endproperty
   a_gated_hold: assert property (p_gated_hold) // [RULE_06]
      else $error("counter moved while controller clock gated");

   property p_halt_hold;
      CE && halt_s2 && !cvr_wr |=> $stable(cvr_reg) && !$rose(zero_flag_reg);
   endproperty
   a_halt_hold: assert property (p_halt_hold) // [RULE_12]
      else $error("counter moved during debug halt");

   property p_decrement;
      CE && cnt_step && !cvr_wr && (cvr_reg != '0) |=> cvr_reg == $past(cvr_reg) - 24'h000001;
   endproperty
   a_decrement: assert property (p_decrement) // [RULE_09]
      else $error("counter did not decrement by one");

   property p_reload;
      CE && cnt_step && !cvr_wr && (cvr_reg == '0) |=> cvr_reg == $past(rvr_reg);
   endproperty
   a_reload: assert property (p_reload) // [RULE_09]
      else $error("counter did not reload at zero");

   property p_cvr_write;
      CE && cvr_wr |=> (cvr_reg == '0) && !zero_flag_reg && !$rose(ist_reg[IRQ_ZERO_BIT]);
   endproperty
   a_cvr_write: assert property (p_cvr_write) // [RULE_10]
      else $error("current write did not clear or raised exception");

   property p_csr_read_clear;
      CE && csr_rd && !hit_zero |=> !zero_flag_reg;
   endproperty
   a_csr_read_clear: assert property (p_csr_read_clear) // [RULE_11]
      else $error("reached zero flag survived control read");

   property p_zero_set;
      CE && hit_zero |=> zero_flag_reg && (cvr_reg == '0);
   endproperty
   a_zero_set: assert property (p_zero_set) // [RULE_11]
      else $error("reached zero flag not set at zero");

   property p_irq_level;
      IRQ == |(ist_reg & imsk_reg);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with status and mask");

   property p_rdata_idle;
      CE && !BUS_REQ.rd |=> RDATA == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data stood beyond its cycle");

   property p_csr_clksrc;
      CE && csr_rd |=> RDATA[CSR_CLKSRC_BIT];
   endproperty
   a_csr_clksrc: assert property (p_csr_clksrc) // [RULE_01]
      else $error("clock source bit read as zero");

   property p_cvr_no_exc;
      CE && cvr_wr |=> ist_reg == $past(ist_reg);
   endproperty
   a_cvr_no_exc: assert property (p_cvr_no_exc) // [RULE_10]
      else $error("current write changed the exception status");

   property p_tick_status;
      CE && hit_zero && ctrl_tickint_reg |=> ist_reg[IRQ_ZERO_BIT];
   endproperty
   a_tick_status: assert property (p_tick_status) // [RULE_09]
      else $error("zero reached without exception status");

   property p_disabled_hold;
      CE && !ctrl_en_reg && !cvr_wr |=> $stable(cvr_reg);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) // [RULE_09]
      else $error("counter moved while disabled");

   property p_flag_hold;
      CE && !hit_zero && !csr_rd && !cvr_wr |=> $stable(zero_flag_reg);
   endproperty
   a_flag_hold: assert property (p_flag_hold) // [RULE_11]
      else $error("reached zero flag changed without cause");
endmodule

// >>> tb.sv
// Purpose: self-checking bench for the tick timer register port
// Assumes: word accesses; 25 MHz clock; reset held 12 cycles
// Notes: expected values follow the register map and counter rules
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import stc_pkg::*;
   logic SYS_CLK;
   logic RST;
   logic CE;
   logic IC_CLK_RUN;
   logic DBG_HALT;
   logic IRQ;
   stc_bus_req_t BUS_REQ;
   logic [DATA_W-1:0] RDATA;
   int failures = 0;
   int n_checks = 0;
   int k;
   logic [31:0] v;
   logic [31:0] w;
   // tick period in cycles worked out from the 40 ns clock, 1 us
   localparam int CLK_NS = 40;
   localparam int TICK_US = 1000 / CLK_NS;

   stc_tick_timer i_dut (
      .SYS_CLK(SYS_CLK),
      .RST(RST),
      .CE(CE),
      .BUS_REQ(BUS_REQ),
      .IC_CLK_RUN(IC_CLK_RUN),
      .DBG_HALT(DBG_HALT),
      .RDATA(RDATA),
      .IRQ(IRQ)
   );

   initial begin
      SYS_CLK = 1'b0;
      forever #20 SYS_CLK = ~SYS_CLK;
   end

   task stop_test;
      if (failures == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK);
      BUS_REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge SYS_CLK);
      BUS_REQ.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe edge
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge SYS_CLK);
      BUS_REQ <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge SYS_CLK);
      BUS_REQ.rd <= 1'b0;
      #1 d = RDATA;
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask

   task wait_irq;
      k = 0;
      while (IRQ !== 1'b1 && k < 60) begin
         @(posedge SYS_CLK);
         k++;
      end
      #1;
   endtask

   initial begin
      repeat (3000) @(posedge SYS_CLK);
      failures++;
      stop_test();
   end

   initial begin
      RST = 1'b1;
      CE = 1'b1;
      IC_CLK_RUN = 1'b1;
      DBG_HALT = 1'b0;
      BUS_REQ = '0;
      repeat (12) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd(OFS_CALIB, v);
      check({31'h0, v[CAL_NO_REFERENCE_CLOCK_FLAG_BIT]}, 32'h1);
      check({31'h0, v[CAL_INEXACT_CALIBRATION_FLAG_BIT]}, 32'h1);
      check({8'h0, v[23:0]}, 32'h0);
      check({26'h0, v[29:24]}, 32'h0);
      wr(OFS_CALIB, 32'hffffffff);
      rdc(OFS_CALIB, 32'hc0000000);
      rdc(OFS_CSR, 32'h4);
      rdc(OFS_RVR, 32'h0);
      rdc(OFS_CVR, 32'h0);
      rdc(OFS_IST, 32'h0);
      rdc(OFS_IMSK, 32'h0);
      rdc(8'h00, 32'h0);
      // write with clock enable low is dropped
      @(posedge SYS_CLK) CE <= 1'b0;
      wr(OFS_RVR, 32'h7);
      CE <= 1'b1;
      rdc(OFS_RVR, 32'h0);
      // reload, clear current, then control
      wr(OFS_RVR, 32'h2);
      wr(OFS_CVR, 32'h123);
      wr(OFS_IMSK, 32'h1);
      wr(OFS_CSR, 32'h3);
      wait_irq();
      check({31'h0, IRQ}, 32'h1);
      // reads two steps apart walk 2,1,0 backwards by two
      rd(OFS_CVR, w);
      repeat (6) begin
         rd(OFS_CVR, v);
         check(v, (w == 32'h2) ? 32'h0 : ((w == 32'h0) ? 32'h1 : 32'h2));
         w = v;
      end
      @(posedge SYS_CLK) DBG_HALT <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      rd(OFS_CVR, w);
      rd(OFS_CVR, v);
      check(v, w);
      rdc(OFS_CSR, 32'h10007);
      rdc(OFS_CSR, 32'h7);
      rdc(OFS_IST, 32'h1);
      wr(OFS_IMSK, 32'h0);
      #1 check({31'h0, IRQ}, 32'h0);
      wr(OFS_IMSK, 32'h1);
      #1 check({31'h0, IRQ}, 32'h1);
      wr(OFS_IST, 32'h1);
      #1 check({31'h0, IRQ}, 32'h0);
      rdc(OFS_IST, 32'h0);
      // count again, then clear current while halted
      @(posedge SYS_CLK) DBG_HALT <= 1'b0;
      wait_irq();
      check({31'h0, IRQ}, 32'h1);
      @(posedge SYS_CLK) DBG_HALT <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      wr(OFS_IST, 32'h1);
      wr(OFS_RVR, 32'h100);
      wr(OFS_CVR, 32'h55);
      rdc(OFS_CSR, 32'h7);
      rdc(OFS_CVR, 32'h0);
      rdc(OFS_IST, 32'h0);
      @(posedge SYS_CLK) DBG_HALT <= 1'b0;
      repeat (10) @(posedge SYS_CLK);
      rd(OFS_CVR, v);
      // two sync edges, one reload step, then eight decrements
      check(v, 32'hf8);
      // controller clock gated holds the count
      @(posedge SYS_CLK) IC_CLK_RUN <= 1'b0;
      repeat (4) @(posedge SYS_CLK);
      rd(OFS_CVR, w);
      rd(OFS_CVR, v);
      check(v, w);
      @(posedge SYS_CLK) IC_CLK_RUN <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      rd(OFS_CVR, v);
      check({31'h0, v < w}, 32'h1);
      // software picks the reload from the known clock period
      wr(OFS_RVR, 32'(TICK_US - 1));
      wr(OFS_CVR, 32'h0);
      rdc(OFS_RVR, 32'(TICK_US - 1));
      // reload on the first step after the clear, then two decrements
      rdc(OFS_CVR, 32'(TICK_US - 3));
      wr(OFS_CSR, 32'h0);
      repeat (3) @(posedge SYS_CLK);
      rd(OFS_CVR, w);
      rd(OFS_CVR, v);
      check(v, w);
      stop_test();
   end
endmodule
